// *** src/wdc_data_cache.sv ***
// Functional notes
// [RQ1] 1KB, two ways, 32 sets, 16-byte lines.
// [RQ2] Stores write only the addressed bytes of a line.
// [RQ3] Store hits update only the cache; memory sees only modified lines.
// [RQ4] A modified victim line is written back before it is replaced.
// [RQ5] One cacheability enable per 128MB region; disabled regions are non-cacheable.
// [RQ6] With translation on, a cache-inhibited page is non-cacheable.
// [RQ7] Non-cacheable accesses and fill data use a direct bypass path.
// [RQ8] Fills and write-backs start only from processor loads, stores or cache operations.
// [RQ9] Fills start at the requested word, ascend, then wrap to the line start.
// [RQ10] Supports invalidate, touch, zero, flush and store-line operations.
// [RQ11] Twenty-eight 128MB regions selected by the upper physical address bits.
// [RQ12] Misses and non-cacheable accesses hand their address to the bus interface.
// [RQ13] The bus interface bursts line fills and write-backs to suitable memory.
// [RQ14] Valid and modified per line; LRU per set, invalid way preferred.
// [RQ15] Reset clears all valid and modified flags.
`timescale 1ns/100ps
module wdc_data_cache (
  // Clock and reset.
  input  wire logic                   mclk,
  input  wire logic                   arst_n,
  // Request from the execution unit.
  input  wire logic                   req_valid,
  input  wdc_pkg::wdc_op_t            req_op,
  input  wire logic [31:0]            req_addr,
  input  wire logic [3:0]             req_be,
  input  wire logic [31:0]            req_wdata,
  // Cacheability controls.
  input  wire logic [27:0]            region_en,
  input  wire logic                   xlat_en,
  input  wire logic                   page_inhibit,
  // Answer to the execution unit.
  output logic                        busy_r,
  output logic                        resp_valid_r,
  output logic [31:0]                 resp_rdata_r,
  // Toward the external bus interface.
  output logic                        bus_req_r,
  output logic                        bus_we_r,
  output logic                        bus_burst_r,
  output logic [31:0]                 bus_addr_r,
  output logic [31:0]                 bus_wdata_r,
  output logic [3:0]                  bus_be_r,
  input  wire logic                   bus_ack,
  input  wire logic [31:0]            bus_rdata
);
  import wdc_pkg::*;
  // Latched request and controller state.
  wdc_state_t        st_r;
  wdc_op_t           op_r;
  logic [31:0]       addr_r, wdata_r, byp_data_r;
  logic [3:0]        be_r;
  logic              cach_r, way_r, hit_r, fwd_r;
  logic [1:0]        wcnt_r;
  // Storage: tags and data per way and set, flags as bit vectors per way.
  logic [TAG_W-1:0]  tag_mem  [WAYS][SETS];                        // [RQ1]
  logic [31:0]       data_mem [WAYS][SETS][WORDS];                 // [RQ1]
  logic [SETS-1:0]   valid_r  [WAYS];
  logic [SETS-1:0]   dirty_r  [WAYS];
  logic [SETS-1:0]   lru_r;
  // Lookup decode and handshake terms.
  logic [IDX_W-1:0]  idx;
  logic [TAG_W-1:0]  tag;
  logic [1:0]        word, fill_word;
  logic              hit0, hit1, hit_any, vict, lk_way, lk_dirty;
  logic              is_alloc, wb_need, take, beat, region_ok;
  logic [31:0]       sel_word, wmask;
  // Address split and tag compare on the latched request.
  assign idx       = addr_r[TAG_LSB-1:IDX_LSB];
  assign tag       = addr_r[31:TAG_LSB];
  assign word      = addr_r[3:2];
  assign fill_word = word + wcnt_r;                                // [RQ9]
  assign hit0      = valid_r[0][idx] && (tag_mem[0][idx] == tag);
  assign hit1      = valid_r[1][idx] && (tag_mem[1][idx] == tag);
  assign hit_any   = hit0 || hit1;
  // An empty way is always filled before the LRU choice is used.
  assign vict      = !valid_r[0][idx] ? 1'b0 : (!valid_r[1][idx] ? 1'b1 : lru_r[idx]);   // [RQ14]
  assign lk_way    = hit_any ? hit1 : vict;
  assign lk_dirty  = valid_r[lk_way][idx] && dirty_r[lk_way][idx];
  assign is_alloc  = (op_r == WDC_LOAD) || (op_r == WDC_STORE) || (op_r == WDC_TOUCH);
  // Flush and store-line write back a dirty hit; allocation writes back a dirty victim.
  assign wb_need   = cach_r && lk_dirty &&
                     (hit_any ? ((op_r == WDC_FLUSH) || (op_r == WDC_STLINE))
                              : (is_alloc || (op_r == WDC_ZERO)));                // [RQ4] [RQ10]
  assign take      = req_valid && !busy_r;
  assign beat      = bus_req_r && bus_ack;
  // Region index above the last region is never cacheable.
  assign region_ok = (req_addr[31:REGION_LSB] < REGION_LIM) && region_en[req_addr[31:REGION_LSB]];  // [RQ11]
  assign sel_word  = data_mem[way_r][idx][word];
  assign wmask     = {{8{be_r[3]}}, {8{be_r[2]}}, {8{be_r[1]}}, {8{be_r[0]}}};
  // Request capture and the sequencing state machine.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r    <= WDC_IDLE;
      op_r    <= WDC_LOAD;
      addr_r  <= 32'h0;
      wdata_r <= 32'h0;
      be_r    <= 4'h0;
      cach_r  <= 1'b0;
      way_r   <= 1'b0;
      hit_r   <= 1'b0;
      wcnt_r  <= 2'h0;
    end else begin
      case (st_r)
        WDC_IDLE: begin
          if (take) begin
            op_r    <= req_op;
            addr_r  <= req_addr;
            wdata_r <= req_wdata;
            be_r    <= req_be;
            cach_r  <= region_ok && !(xlat_en && page_inhibit);   // [RQ5] [RQ6]
            st_r    <= WDC_LOOKUP;
          end
        end
        WDC_LOOKUP: begin
          way_r  <= lk_way;
          hit_r  <= hit_any;
          wcnt_r <= 2'h0;
          if (!cach_r) begin
            st_r <= ((op_r == WDC_LOAD) || (op_r == WDC_STORE)) ? WDC_BYP : WDC_FIN;   // [RQ7] [RQ12]
          end else if (wb_need) begin
            st_r <= WDC_WB;                                        // [RQ4]
          end else if (!hit_any && is_alloc) begin
            st_r <= WDC_FILL;                                      // [RQ12]
          end else begin
            st_r <= WDC_FIN;                                       // [RQ3]
          end
        end
        WDC_WB: begin
          if (beat) begin
            wcnt_r <= wcnt_r + 2'h1;
            if (wcnt_r == LAST_BEAT) begin
              st_r <= is_alloc ? WDC_FILL : WDC_FIN;
            end
          end
        end
        WDC_FILL: begin
          if (beat) begin
            wcnt_r <= wcnt_r + 2'h1;
            if (wcnt_r == LAST_BEAT) begin
              st_r <= WDC_FIN;
            end
          end
        end
        WDC_BYP: begin
          if (beat) begin
            st_r <= WDC_FIN;
          end
        end
        WDC_FIN: st_r <= WDC_IDLE;
        default: st_r <= WDC_IDLE;
      endcase
    end
  end
  // Answer to the execution unit; fill and bypass data is forwarded directly.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busy_r       <= 1'b0;
      resp_valid_r <= 1'b0;
      resp_rdata_r <= 32'h0;
      fwd_r        <= 1'b0;
      byp_data_r   <= 32'h0;
    end else begin
      resp_valid_r <= (st_r == WDC_FIN);
      if (take) begin
        busy_r <= 1'b1;
        fwd_r  <= 1'b0;
      end else if (st_r == WDC_FIN) begin
        busy_r       <= 1'b0;
        resp_rdata_r <= fwd_r ? byp_data_r : sel_word;
      end
      if (beat && ((st_r == WDC_BYP) || ((st_r == WDC_FILL) && (fill_word == word)))) begin
        fwd_r      <= 1'b1;                                        // [RQ7]
        byp_data_r <= bus_rdata;
      end
    end
  end
  // Bus requests; one beat at a time, each held until the bus acknowledges it.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bus_req_r   <= 1'b0;
      bus_we_r    <= 1'b0;
      bus_burst_r <= 1'b0;
      bus_addr_r  <= 32'h0;
      bus_wdata_r <= 32'h0;
      bus_be_r    <= 4'h0;
    end else if (beat) begin
      bus_req_r <= 1'b0;
    end else if (!bus_req_r && ((st_r == WDC_WB) || (st_r == WDC_FILL) || (st_r == WDC_BYP))) begin
      bus_req_r   <= 1'b1;                                         // [RQ8] [RQ12]
      // A store miss fills by reading; only write-backs and bypassed stores write.
      bus_we_r    <= (st_r == WDC_WB) || ((st_r == WDC_BYP) && (op_r == WDC_STORE));
      bus_burst_r <= (st_r != WDC_BYP);                            // [RQ13]
      bus_be_r    <= (st_r == WDC_BYP) ? be_r : 4'hF;
      bus_wdata_r <= (st_r == WDC_WB) ? data_mem[way_r][idx][wcnt_r] : wdata_r;
      case (st_r)
        WDC_WB:   bus_addr_r <= {tag_mem[way_r][idx], idx, wcnt_r, 2'h0};
        WDC_FILL: bus_addr_r <= {tag, idx, fill_word, 2'h0};       // [RQ9]
        default:  bus_addr_r <= addr_r;
      endcase
    end
  end
  // Line flags; reset leaves the cache empty.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      valid_r[0] <= '0;                                            // [RQ15]
      valid_r[1] <= '0;
      dirty_r[0] <= '0;
      dirty_r[1] <= '0;
      lru_r      <= '0;
    end else if (beat && (wcnt_r == LAST_BEAT) && (st_r == WDC_WB)) begin
      dirty_r[way_r][idx] <= 1'b0;                                 // [RQ3]
      if (is_alloc || (op_r == WDC_ZERO)) begin
        valid_r[way_r][idx] <= 1'b0;
      end
    end else if (beat && (wcnt_r == LAST_BEAT) && (st_r == WDC_FILL)) begin
      valid_r[way_r][idx] <= 1'b1;
      dirty_r[way_r][idx] <= 1'b0;
    end else if ((st_r == WDC_FIN) && cach_r) begin
      case (op_r)
        WDC_STORE: begin
          dirty_r[way_r][idx] <= 1'b1;                             // [RQ3]
          lru_r[idx]          <= ~way_r;                           // [RQ14]
        end
        WDC_LOAD, WDC_TOUCH: begin
          lru_r[idx] <= ~way_r;
        end
        WDC_ZERO: begin
          valid_r[way_r][idx] <= 1'b1;                             // [RQ10]
          dirty_r[way_r][idx] <= 1'b1;
          lru_r[idx]          <= ~way_r;
        end
        WDC_INVAL, WDC_FLUSH: begin
          if (hit_r) begin
            valid_r[way_r][idx] <= 1'b0;                           // [RQ10]
            dirty_r[way_r][idx] <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end
  // Tag and data arrays; stores touch only the enabled byte lanes.
  always_ff @(posedge mclk) begin
    if (beat && (st_r == WDC_FILL)) begin
      data_mem[way_r][idx][fill_word] <= bus_rdata;
      if (wcnt_r == LAST_BEAT) begin
        tag_mem[way_r][idx] <= tag;
      end
    end else if ((st_r == WDC_FIN) && cach_r && (op_r == WDC_STORE)) begin
      for (int b = 0; b < 4; b++) begin
        if (be_r[b]) begin
          data_mem[way_r][idx][word][8*b +: 8] <= wdata_r[8*b +: 8];   // [RQ2]
        end
      end
    end else if ((st_r == WDC_FIN) && cach_r && (op_r == WDC_ZERO)) begin
      tag_mem[way_r][idx] <= tag;
      for (int w = 0; w < WORDS; w++) begin
        data_mem[way_r][idx][w] <= 32'h0;                          // [RQ10]
      end
    end
  end
  // Checks.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence store_hit_s;
    (st_r == WDC_LOOKUP) && cach_r && hit_any && (op_r == WDC_STORE);
  endsequence

  sequence local_finish_s;
    (st_r == WDC_FIN) && !bus_req_r ##1 resp_valid_r && !bus_req_r;
  endsequence

  no_spont_bus_a: assert property (bus_req_r |-> busy_r && (st_r != WDC_IDLE))   // [RQ8]
    else $error("Bus request without a processor operation");
  store_hit_local_a: assert property (store_hit_s |=> local_finish_s)              // [RQ3]
    else $error("Store hit reached the bus");
  byte_lanes_a: assert property ((st_r == WDC_FIN) && cach_r && (op_r == WDC_STORE)  // [RQ2]
                                 |=> ((sel_word ^ $past(sel_word)) & ~$past(wmask)) == 32'h0)
    else $error("Store changed a disabled byte lane");
  victim_wb_a: assert property ((st_r == WDC_LOOKUP) && cach_r && !hit_any && is_alloc && lk_dirty  // [RQ4]
                                |=> (st_r == WDC_WB))
    else $error("Dirty victim not written back first");
  fill_order_a: assert property (bus_req_r && (st_r == WDC_FILL)                   // [RQ9]
                                 |-> bus_addr_r[3:2] == fill_word)
    else $error("Fill word out of wrap order");
  page_inhibit_a: assert property (take && xlat_en && page_inhibit |=> !cach_r)    // [RQ6]
    else $error("Inhibited page treated as cacheable");
  region_limit_a: assert property (take && (req_addr[31:REGION_LSB] >= REGION_LIM) |=> !cach_r)  // [RQ11]
    else $error("Address beyond last region cacheable");
  bypass_path_a: assert property ((st_r == WDC_LOOKUP) && !cach_r && (op_r == WDC_LOAD)   // [RQ7]
                                  |=> (st_r == WDC_BYP) ##1 bus_req_r && !bus_burst_r && (bus_addr_r == addr_r))
    else $error("Non-cacheable load missed the bypass path");
  line_burst_a: assert property (bus_req_r && ((st_r == WDC_WB) || (st_r == WDC_FILL)) |-> bus_burst_r)  // [RQ13]
    else $error("Line transfer not marked as burst");

endmodule : wdc_data_cache

// *** src/wdc_pkg.sv ***
package wdc_pkg;

  // Geometry of the data array.
  localparam int WAYS        = 2;
  localparam int SETS        = 32;
  localparam int LINE_BYTES  = 16;
  localparam int WORDS       = 4;
  localparam int IDX_LSB     = 4;
  localparam int IDX_W       = 5;
  localparam int TAG_LSB     = 9;
  localparam int TAG_W       = 23;

  // Cacheability regions of 128MB each, picked by the top address bits.
  localparam int         REGION_LSB  = 27;
  localparam int         NUM_REGIONS = 28;
  localparam logic [4:0] REGION_LIM  = 5'h1C;

  // Beat counter value of the last beat of a line transfer.
  localparam logic [1:0] LAST_BEAT = 2'h3;

  // Operations that the execution unit can issue.
  typedef enum logic [2:0] {
    WDC_LOAD,
    WDC_STORE,
    WDC_INVAL,
    WDC_TOUCH,
    WDC_ZERO,
    WDC_FLUSH,
    WDC_STLINE
  } wdc_op_t;

  // Controller states.
  typedef enum logic [2:0] {
    WDC_IDLE,
    WDC_LOOKUP,
    WDC_WB,
    WDC_FILL,
    WDC_BYP,
    WDC_FIN
  } wdc_state_t;

endpackage : wdc_pkg

// *** verif/tb_wdc_data_cache.sv ***
`timescale 1ns/100ps
module tb_wdc_data_cache;
  import wdc_pkg::*;
  // Design ports and bench state.
  logic mclk, arst_n, req_valid, xlat_en, page_inhibit, slow;
  wdc_op_t req_op;
  logic [31:0] req_addr, req_wdata, resp_rdata_r, bus_addr_r, bus_wdata_r, bus_rdata;
  logic [3:0] req_be, bus_be_r;
  logic [27:0] region_en;
  logic busy_r, resp_valid_r, bus_req_r, bus_we_r, bus_burst_r, bus_ack;
  logic [31:0] q_addr[$], ref_m[int unsigned];
  logic q_we[$], q_burst[$];
  logic [3:0] q_be[$];
  int err_total, checks_done, lat, cyc;

  wdc_data_cache wdc_data_cache_inst (.mclk(mclk), .arst_n(arst_n), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata), .region_en(region_en), .xlat_en(xlat_en),
    .page_inhibit(page_inhibit), .busy_r(busy_r), .resp_valid_r(resp_valid_r), .resp_rdata_r(resp_rdata_r),
    .bus_req_r(bus_req_r), .bus_we_r(bus_we_r), .bus_burst_r(bus_burst_r), .bus_addr_r(bus_addr_r),
    .bus_wdata_r(bus_wdata_r), .bus_be_r(bus_be_r), .bus_ack(bus_ack), .bus_rdata(bus_rdata));
  wdc_bus_mem wdc_bus_mem_inst (.mclk(mclk), .arst_n(arst_n), .bus_req(bus_req_r), .bus_we(bus_we_r),
    .bus_addr(bus_addr_r), .bus_wdata(bus_wdata_r), .bus_be(bus_be_r), .slow(slow), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Every completed beat is logged so ordering can be judged after the operation.
  always @(posedge mclk) begin
    if (bus_req_r && bus_ack) begin
      q_addr.push_back(bus_addr_r);
      q_we.push_back(bus_we_r);
      q_burst.push_back(bus_burst_r);
      q_be.push_back(bus_be_r);
    end
  end

  // A hung handshake must not stall the run, so the cycle budget is capped.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Logical memory contents as the processor should see them.
  function automatic logic [31:0] ref_rd(input logic [31:0] a);
    return ref_m.exists(a[31:2]) ? ref_m[a[31:2]] : {a[31:2], 2'h0} ^ 32'h5A0F_C3A5;
  endfunction : ref_rd

  // One request, waited for under a bound; loads are compared and the model updated.
  task automatic op(input wdc_op_t o, input logic [31:0] a, input logic [3:0] be, input logic [31:0] wd,
                    input int beats);
    logic [31:0] w;
    w = ref_rd(a);
    q_addr.delete();
    q_we.delete();
    q_burst.delete();
    q_be.delete();
    @(negedge mclk);
    req_valid = 1'b1;
    req_op = o;
    req_addr = a;
    req_be = be;
    req_wdata = wd;
    @(posedge mclk);
    lat = 1;
    @(negedge mclk);
    req_valid = 1'b0;
    while (resp_valid_r !== 1'b1 && lat < 500) begin
      @(posedge mclk);
      #1;
      lat++;
    end
    // A wait that ran out of its bound counts as a mismatch here.
    chk("response", {31'h0, resp_valid_r}, 32'h1);
    if (o == WDC_LOAD) chk("load data", resp_rdata_r, w);
    for (int b = 0; b < 4; b++) if (be[b]) w[8*b +: 8] = wd[8*b +: 8];
    if (o == WDC_STORE) ref_m[a[31:2]] = w;
    if (o == WDC_ZERO) for (int i = 0; i < 4; i++) ref_m[{a[31:4], 2'(i)}] = 32'h0000_0000;
    if (beats >= 0) chk("beat count", q_addr.size(), beats);
  endtask : op

  // Four beats from index i0 must be one line transfer starting at word w and wrapping.
  task automatic chk_line(input int i0, input logic [31:0] a, input logic [1:0] w, input logic we);
    for (int i = 0; i < 4; i++) begin
      chk("beat addr", q_addr[i0+i], {a[31:4], 2'(w + i), 2'h0});
      chk("beat dir", {30'h0, q_we[i0+i], q_burst[i0+i]}, {30'h0, we, 1'b1});
    end
  endtask : chk_line

  // A single non-burst beat at exactly the request address.
  task automatic chk_byp(input logic [31:0] a, input logic we, input logic [3:0] be);
    chk("bypass addr", q_addr[0], a);
    chk("bypass kind", {26'h0, q_we[0], q_burst[0], q_be[0]}, {26'h0, we, 1'b0, be});
  endtask : chk_byp

  initial begin
    logic [31:0] a;
    {arst_n, req_valid, xlat_en, page_inhibit, slow, req_be} = '0;
    {req_addr, req_wdata} = '0;
    req_op = WDC_LOAD;
    region_en = 28'hFFF_FFFF;
    void'($urandom(4915));
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    arst_n = 1'b1;
    chk("idle outputs", {29'h0, busy_r, resp_valid_r, bus_req_r}, 32'h0);
    // Cold miss, then a two-byte store hit that stays inside the cache.
    op(WDC_LOAD, 32'h0000_0128, 4'hF, 0, 4);
    chk_line(0, 32'h0000_0128, 2'h2, 1'b0);
    op(WDC_STORE, 32'h0000_0128, 4'h6, 32'hDEAD_BEEF, 0);
    chk("hit latency", lat, 3);
    op(WDC_LOAD, 32'h0000_0128, 4'hF, 0, 0);
    $display("test fill_and_hit done");
    // Third tag in the set evicts the dirty least recent line first.
    slow = 1'b1;
    op(WDC_LOAD, 32'h0000_0328, 4'hF, 0, 4);
    op(WDC_LOAD, 32'h0000_0528, 4'hF, 0, 8);
    chk_line(0, 32'h0000_0128, 2'h0, 1'b1);
    chk_line(4, 32'h0000_0528, 2'h2, 1'b0);
    op(WDC_LOAD, 32'h0000_0128, 4'hF, 0, 4);
    $display("test evict done");
    // Every cache control operation.
    op(WDC_TOUCH, 32'h0000_0230, 4'hF, 0, 4);
    op(WDC_ZERO, 32'h0000_0234, 4'hF, 0, 0);
    op(WDC_LOAD, 32'h0000_0238, 4'hF, 0, 0);
    op(WDC_STLINE, 32'h0000_0230, 4'hF, 0, 4);
    chk_line(0, 32'h0000_0230, 2'h0, 1'b1);
    op(WDC_STLINE, 32'h0000_0230, 4'hF, 0, 0);
    op(WDC_STORE, 32'h0000_0230, 4'hF, 32'h1234_5678, 0);
    op(WDC_FLUSH, 32'h0000_0230, 4'hF, 0, 4);
    op(WDC_LOAD, 32'h0000_0230, 4'hF, 0, 4);
    op(WDC_INVAL, 32'h0000_0230, 4'hF, 0, 0);
    op(WDC_LOAD, 32'h0000_023C, 4'hF, 0, 4);
    chk_line(0, 32'h0000_023C, 2'h3, 1'b0);
    $display("test cache_ops done");
    // Non-cacheable accesses by region, by top region and by page.
    region_en[0] = 1'b0;
    op(WDC_STORE, 32'h0000_0340, 4'h3, 32'hCAFE_F00D, 1);
    chk_byp(32'h0000_0340, 1'b1, 4'h3);
    op(WDC_LOAD, 32'h0000_0340, 4'hF, 0, 1);
    op(WDC_TOUCH, 32'h0000_0340, 4'hF, 0, 0);
    region_en = 28'hFFF_FFFF;
    op(WDC_LOAD, 32'hE000_0014, 4'hF, 0, 1);
    chk_byp(32'hE000_0014, 1'b0, 4'hF);
    region_en[27] = 1'b0;
    op(WDC_LOAD, 32'hD800_0018, 4'hF, 0, 1);
    region_en[27] = 1'b1;
    op(WDC_LOAD, 32'hD800_0018, 4'hF, 0, 4);
    {xlat_en, page_inhibit} = 2'b11;
    op(WDC_LOAD, 32'h0000_0450, 4'hF, 0, 1);
    chk_byp(32'h0000_0450, 1'b0, 4'hF);
    page_inhibit = 1'b0;
    op(WDC_LOAD, 32'h0000_0450, 4'hF, 0, 4);
    xlat_en = 1'b0;
    $display("test bypass done");
    // A reset in mid-run must empty the cache, so a line cached before misses again.
    @(negedge mclk);
    arst_n = 1'b0;
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    chk("idle outputs", {29'h0, busy_r, resp_valid_r, bus_req_r}, 32'h0);
    op(WDC_LOAD, 32'h0000_0450, 4'hF, 0, 4);
    $display("test reset done");
    // Random traffic on two sets and four tags, then everything flushed out.
    for (int i = 0; i < 80; i++) begin
      slow = 1'($urandom);
      a = {20'h0, 2'($urandom), 4'h0, 1'($urandom), 1'b1, 2'($urandom), 2'h0};
      op($urandom_range(1) ? WDC_STORE : WDC_LOAD, a, 4'($urandom_range(15, 1)), $urandom, -1);
    end
    for (int i = 0; i < 16; i++) op(WDC_FLUSH, {20'h0, 2'(i / 4), 4'h0, 2'(i), 4'h0}, 4'hF, 0, -1);
    for (int i = 0; i < 64; i++) begin
      a = {20'h0, 2'(i / 16), 4'h0, 1'(i / 8), 1'b1, 2'(i), 2'h0};
      chk("memory word", wdc_bus_mem_inst.peek(a), ref_rd(a));
    end
    $display("test random done");
    test_done();
  end
endmodule : tb_wdc_data_cache

// *** verif/wdc_bus_mem.sv ***
`timescale 1ns/100ps
// Far side of the cache: memory behind the external bus interface, one ack per beat.
module wdc_bus_mem (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // Beat request from the cache.
  input  wire logic        bus_req,
  input  wire logic        bus_we,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic [3:0]  bus_be,
  input  wire logic        slow,
  // Answer to the cache.
  output logic             bus_ack,
  output logic [31:0]      bus_rdata
);
  logic [31:0] mem [int unsigned];
  int          wait_cnt;

  // Words never written read back a pattern tied to their address.
  function automatic logic [31:0] peek(input logic [31:0] a);
    return mem.exists(a[31:2]) ? mem[a[31:2]] : {a[31:2], 2'h0} ^ 32'h5A0F_C3A5;
  endfunction : peek

  // Every beat, single or within a burst, is acked once after a short or long stall.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bus_ack  <= 1'b0;
      wait_cnt <= 0;
    end else if (bus_ack) begin
      bus_ack <= 1'b0;
      if (bus_we) begin
        logic [31:0] w;
        w = peek(bus_addr);
        for (int b = 0; b < 4; b++) if (bus_be[b]) w[8*b +: 8] = bus_wdata[8*b +: 8];
        mem[bus_addr[31:2]] = w;
      end
    end else if (bus_req && wait_cnt >= (slow ? 3 : 0)) begin
      bus_ack  <= 1'b1;
      wait_cnt <= 0;
    end else if (bus_req) begin
      wait_cnt <= wait_cnt + 1;
    end
  end

  // Outside an ack the data lines carry no stale word, so a late sample shows up.
  assign bus_rdata = bus_ack ? peek(bus_addr) : ~bus_addr;
endmodule : wdc_bus_mem
